// ---- rtl/apps_prot_seq.sv ----
// Output driver protection and chip enable power sequencer of the amplifier.
// Operation
// - Drivers turn off at once when the overtemperature flag is raised.
// - After thermal shutdown, drivers return after the safe flag holds 47 ms.
// - A short flagged for 14 us turns drivers off for 47 ms.
// - When the off time ends, drivers come back and shorts are watched again.
// - Detect, off, retry repeats until the short is gone.
// - The overcurrent comparator flag is the short condition feeding the timer.
// - Undervoltage flag disables drivers while the control logic keeps running.
// - Power-on reset forces the whole block into power down.
// - After power-on reset drivers and bias stay powered down until enable is high; the PWM sweep keeps running.
// - Enable high runs a power-up sequence of 3.4 ms before output.
// - Enable low completes power down in about 30 us.
// - PWM oscillator sweeps 300 kHz plus or minus 15 kHz.
`timescale 1ns/1ps
module apps_prot_seq
   import apps_pkg::*;
#(
   parameter int unsigned THERM_CYC = THERM_SAFE_CYC,
   parameter int unsigned SOFF_CYC  = SHORT_OFF_CYC,
   parameter int unsigned SDET_CYC  = SHORT_DET_CYC,
   parameter int unsigned UP_CYC    = PWRUP_CYC,
   parameter int unsigned DOWN_CYC  = PWRDN_CYC,
   parameter int unsigned CNT_W     = 24
) (
   // Clock and power-on reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Host chip enable
   input  wire logic              chip_en,
   // Analog flags
   input  wire apps_ana_type      ana,
   // Driver and bias control, status and PWM frequency word
   output logic                   drv_en,
   output logic                   bias_en,
   output apps_stat_type          status,
   output logic [FREQ_W-1:0]      pwm_freq_hz
);

   localparam logic [CNT_W-1:0] C_ONE   = CNT_W'(1);
   localparam logic [CNT_W-1:0] C_ZERO  = CNT_W'(0);
   localparam logic [CNT_W-1:0] C_THERM = CNT_W'(THERM_CYC);
   localparam logic [CNT_W-1:0] C_SOFF  = CNT_W'(SOFF_CYC);
   localparam logic [CNT_W-1:0] C_SDET  = CNT_W'(SDET_CYC);
   localparam logic [CNT_W-1:0] C_UP    = CNT_W'(UP_CYC);
   localparam logic [CNT_W-1:0] C_DOWN  = CNT_W'(DOWN_CYC);

   apps_seq_type     seq_r;
   logic [CNT_W-1:0] seq_cnt_r;
   logic             therm_off_r;
   logic [CNT_W-1:0] therm_cnt_r;
   logic             short_off_r;
   logic [CNT_W-1:0] sdet_cnt_r;
   logic [CNT_W-1:0] soff_cnt_r;
   logic             short_trip;
   logic             prot_any;

   // Power sequencer; reset is the power-on reset, so it lands in OFF.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_r     <= APPS_OFF;
         seq_cnt_r <= C_ZERO;
      end else begin
         case (seq_r)
            APPS_OFF: begin
               seq_cnt_r <= C_ZERO;
               if (chip_en) begin
                  seq_r <= APPS_UP;
               end
            end
            APPS_UP: begin
               if (!chip_en) begin
                  seq_r     <= APPS_DOWN;
                  seq_cnt_r <= C_ZERO;
               end else if (seq_cnt_r == C_UP - C_ONE) begin
                  seq_r     <= APPS_ON;
                  seq_cnt_r <= C_ZERO;
               end else begin
                  seq_cnt_r <= seq_cnt_r + C_ONE;
               end
            end
            APPS_ON: begin
               seq_cnt_r <= C_ZERO;
               if (!chip_en) begin
                  seq_r <= APPS_DOWN;
               end
            end
            APPS_DOWN: begin
               if (seq_cnt_r == C_DOWN - C_ONE) begin
                  seq_r     <= APPS_OFF;
                  seq_cnt_r <= C_ZERO;
               end else begin
                  seq_cnt_r <= seq_cnt_r + C_ONE;
               end
            end
            default: begin
               seq_r     <= APPS_OFF;
               seq_cnt_r <= C_ZERO;
            end
         endcase
      end
   end

   // Thermal latch; any hot reading restarts the cool-down count.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         therm_off_r <= 1'b0;
         therm_cnt_r <= C_ZERO;
      end else if (ana.temp_hot) begin
         therm_off_r <= 1'b1;
         therm_cnt_r <= C_ZERO;
      end else if (therm_off_r) begin
         if (!ana.temp_safe) begin
            therm_cnt_r <= C_ZERO;
         end else if (therm_cnt_r == C_THERM - C_ONE) begin
            therm_off_r <= 1'b0;
            therm_cnt_r <= C_ZERO;
         end else begin
            therm_cnt_r <= therm_cnt_r + C_ONE;
         end
      end
   end

   // Short detect only counts while drivers actually run, so a retry sees the short afresh.
   assign short_trip = ana.short_det && (sdet_cnt_r == C_SDET - C_ONE);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sdet_cnt_r <= C_ZERO;
      end else if (!ana.short_det || !drv_en || short_trip) begin
         sdet_cnt_r <= C_ZERO;
      end else begin
         sdet_cnt_r <= sdet_cnt_r + C_ONE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         short_off_r <= 1'b0;
         soff_cnt_r  <= C_ZERO;
      end else if (short_off_r) begin
         if (soff_cnt_r == C_SOFF - C_ONE) begin
            short_off_r <= 1'b0;
            soff_cnt_r  <= C_ZERO;
         end else begin
            soff_cnt_r <= soff_cnt_r + C_ONE;
         end
      end else if (short_trip && drv_en) begin
         short_off_r <= 1'b1;
         soff_cnt_r  <= C_ZERO;
      end
   end

   assign prot_any = therm_off_r || short_off_r || ana.uvlo || ana.temp_hot;
   assign drv_en   = (seq_r == APPS_ON) && !prot_any;
   assign bias_en  = (seq_r == APPS_UP) || (seq_r == APPS_ON);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status <= '0;
      end else begin
         status.therm_off <= therm_off_r;
         status.short_off <= short_off_r;
         status.uvlo_off  <= ana.uvlo;
         status.pwr_ready <= (seq_r == APPS_ON);
      end
   end

   apps_sweep u_sweep (
      .clk     (clk),
      .rst_b   (rst_b),
      .freq_hz (pwm_freq_hz)
   );

   AST_HOT_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      ana.temp_hot |-> !drv_en)
      else $error("Drivers on while overtemperature flagged.");

   AST_THERM_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(therm_off_r) |-> $past(ana.temp_safe) && !$past(ana.temp_hot))
      else $error("Thermal release without safe temperature.");

   AST_SHORT_TRIP: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(short_off_r) |-> $past(ana.short_det) && $past(sdet_cnt_r) == C_SDET - C_ONE)
      else $error("Short off without full detect time.");

   AST_SHORT_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(short_off_r) |-> $past(soff_cnt_r) == C_SOFF - C_ONE)
      else $error("Short off interval wrong length.");

   AST_SHORT_DRV: assert property (@(posedge clk) disable iff (!rst_b)
      short_off_r |-> !drv_en)
      else $error("Drivers on during short off interval.");

   AST_UVLO_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      ana.uvlo |-> !drv_en)
      else $error("Drivers on under undervoltage.");

   AST_STAY_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      (seq_r == APPS_OFF) && !chip_en |=> seq_r == APPS_OFF)
      else $error("Left power down without enable.");

   AST_UP_TIME: assert property (@(posedge clk) disable iff (!rst_b)
      (seq_r == APPS_ON) && $past(seq_r) == APPS_UP |-> $past(seq_cnt_r) == C_UP - C_ONE)
      else $error("Power-up sequence wrong length.");

   AST_DOWN_TIME: assert property (@(posedge clk) disable iff (!rst_b)
      (seq_r == APPS_OFF) && $past(seq_r) == APPS_DOWN |-> $past(seq_cnt_r) == C_DOWN - C_ONE)
      else $error("Power-down sequence wrong length.");

   AST_DRV_READY: assert property (@(posedge clk) disable iff (!rst_b)
      drv_en |-> seq_r == APPS_ON && !therm_off_r && !short_off_r)
      else $error("Drivers on outside ready state.");

   AST_THERM_LATCH: assert property (@(posedge clk) disable iff (!rst_b)
      ana.temp_hot |=> therm_off_r)
      else $error("Overtemperature not latched.");

   AST_SHORT_RETRY: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(short_off_r) |-> sdet_cnt_r == C_ZERO)
      else $error("Short detect count not restarted after off interval.");

   AST_UP_START: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(bias_en) |-> $past(seq_r) == APPS_OFF && $past(chip_en))
      else $error("Power-up started without enable.");

endmodule // apps_prot_seq

// ---- common/apps_pkg.sv ----
// Package with constants and carrier types of the amplifier protection and power sequencer.
package apps_pkg;

   // Timing figures as given, and the clock they are counted in.
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned THERM_SAFE_MS   = 47;
   localparam int unsigned SHORT_DET_NS    = 14_000;
   localparam int unsigned SHORT_OFF_MS    = 47;
   localparam int unsigned PWRUP_US        = 3_400;
   localparam int unsigned PWRDN_NS        = 30_000;

   // Cycle counts derived from the figures.
   localparam int unsigned THERM_SAFE_CYC  = THERM_SAFE_MS * (CLK_HZ / 1_000);
   localparam int unsigned SHORT_DET_CYC   = (SHORT_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SHORT_OFF_CYC   = SHORT_OFF_MS * (CLK_HZ / 1_000);
   localparam int unsigned PWRUP_CYC       = PWRUP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PWRDN_CYC       = PWRDN_NS / CLK_PERIOD_NS;

   // Spread spectrum sweep: centre and span in Hz, sweep step and dwell.
   localparam int unsigned PWM_CENTER_HZ   = 300_000;
   localparam int unsigned PWM_SPAN_HZ     = 15_000;
   localparam int unsigned PWM_STEP_HZ     = 1_000;
   localparam int unsigned PWM_DWELL_PER   = 4;
   localparam int unsigned FREQ_W          = 20;

   // Power sequencer states, Gray coded along off, ramp up, on, ramp down.
   typedef enum logic [1:0] {
      APPS_OFF  = 2'b00,
      APPS_UP   = 2'b01,
      APPS_ON   = 2'b11,
      APPS_DOWN = 2'b10
   } apps_seq_type;

   // Flags from the analog front end.
   typedef struct packed {
      logic temp_hot;
      logic temp_safe;
      logic short_det;
      logic uvlo;
   } apps_ana_type;

   // Protection state reported out.
   typedef struct packed {
      logic therm_off;
      logic short_off;
      logic uvlo_off;
      logic pwr_ready;
   } apps_stat_type;

endpackage

// ---- rtl/apps_sweep.sv ----
// Triangle sweep of the PWM oscillator frequency word for spread spectrum.
`timescale 1ns/1ps
module apps_sweep
   import apps_pkg::*;
#(
   parameter int unsigned CENTER_HZ = PWM_CENTER_HZ,
   parameter int unsigned SPAN_HZ   = PWM_SPAN_HZ,
   parameter int unsigned STEP_HZ   = PWM_STEP_HZ,
   parameter int unsigned DWELL_CYC = PWM_DWELL_PER * (CLK_HZ / PWM_CENTER_HZ)
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Frequency word in Hz
   output logic [FREQ_W-1:0]      freq_hz
);

   localparam logic [FREQ_W-1:0] F_LO   = FREQ_W'(CENTER_HZ - SPAN_HZ);
   localparam logic [FREQ_W-1:0] F_HI   = FREQ_W'(CENTER_HZ + SPAN_HZ);
   localparam logic [FREQ_W-1:0] F_STEP = FREQ_W'(STEP_HZ);
   localparam logic [FREQ_W-1:0] F_MID  = FREQ_W'(CENTER_HZ);
   localparam logic [15:0]       DWELL  = 16'(DWELL_CYC - 1);

   logic [15:0] dwell_r;
   logic        up_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dwell_r <= 16'h0000;
      end else if (dwell_r == DWELL) begin
         dwell_r <= 16'h0000;
      end else begin
         dwell_r <= dwell_r + 16'h0001;
      end
   end

   // The word bounces between the two edges of the band.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         freq_hz <= F_MID;
         up_r    <= 1'b1;
      end else if (dwell_r == DWELL) begin
         if (up_r) begin
            if (freq_hz + F_STEP >= F_HI) begin
               freq_hz <= F_HI;
               up_r    <= 1'b0;
            end else begin
               freq_hz <= freq_hz + F_STEP;
            end
         end else begin
            if (freq_hz <= F_LO + F_STEP) begin
               freq_hz <= F_LO;
               up_r    <= 1'b1;
            end else begin
               freq_hz <= freq_hz - F_STEP;
            end
         end
      end
   end

   AST_SWEEP_BAND: assert property (@(posedge clk) disable iff (!rst_b)
      freq_hz >= F_LO && freq_hz <= F_HI)
      else $error("Sweep frequency left the band.");

endmodule // apps_sweep

// ---- test/apps_host.sv ----
// Host model that drives chip enable and mutes the audio source around each toggle.
`timescale 1ns/1ps
module apps_host (
   // Clock
   input  wire logic clk,
   // Enable level wanted by the bench
   input  wire logic want_en,
   // Pins toward the amplifier
   output logic      chip_en,
   output logic      audio_mute
);
   initial begin
      chip_en    = 1'b0;
      audio_mute = 1'b0;
   end
   // Mute leads the enable change by a cycle and trails it by one, so no pop reaches the speaker.
   always @(negedge clk) begin
      if (want_en != chip_en && !audio_mute) begin
         audio_mute <= 1'b1;
      end else if (want_en != chip_en) begin
         chip_en <= want_en;
      end else begin
         audio_mute <= 1'b0;
      end
   end
endmodule // apps_host

// ---- test/apps_prot_seq_tb.sv ----
// Self-checking testbench of the protection and power sequencer.
`timescale 1ns/1ps
module apps_prot_seq_tb;
   import apps_pkg::*;
   localparam int unsigned TH = 50, SO = 40, SD = 5, UP = 30, DN = 10;
   logic               clk = 1'b0;
   logic               rst_b, want_en, chip_en, audio_mute, drv_en, bias_en;
   apps_ana_type       ana;
   apps_stat_type      status;
   logic [FREQ_W-1:0]  pwm_freq_hz;
   int                 fails = 0, n_compared = 0, n;
   logic               en_prev_r = 1'b0;
   int                 mute_bad = 0;
   always #4 clk = ~clk;
   // An enable edge seen while the source is not muted would let a pop reach the speaker.
   always @(posedge clk) begin
      if (chip_en !== en_prev_r && audio_mute !== 1'b1) mute_bad++;
      en_prev_r <= chip_en;
   end
   apps_host host (.clk(clk), .want_en(want_en), .chip_en(chip_en), .audio_mute(audio_mute));
   apps_prot_seq #(.THERM_CYC(TH), .SOFF_CYC(SO), .SDET_CYC(SD), .UP_CYC(UP), .DOWN_CYC(DN)) dut (
      .clk(clk), .rst_b(rst_b), .chip_en(chip_en), .ana(ana), .drv_en(drv_en),
      .bias_en(bias_en), .status(status), .pwm_freq_hz(pwm_freq_hz));
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask
   task cyc(int k);
      repeat (k) @(negedge clk);
   endtask
   // Bounded wait so a stuck driver enable cannot hang the run.
   task wait_drv(logic v, output int k);
      k = 0;
      while (drv_en !== v && k < 200) begin
         @(negedge clk);
         k++;
      end
   endtask
   task t_reset;
      chk("rst drv", drv_en, 1'b0);
      chk("rst bias", bias_en, 1'b0);
      chk("rst status", status, 4'h0);
      chk("rst freq", pwm_freq_hz, 32'h0004_93E0);
      rst_b = 1'b1;
      cyc(20);
      chk("idle bias", bias_en, 1'b0);
      chk("idle drv", drv_en, 1'b0);
   endtask
   task t_powerup;
      want_en <= 1'b1;
      n = 0;
      while (bias_en !== 1'b1 && n < 10) begin
         cyc(1);
         n++;
      end
      chk("up bias", bias_en, 1'b1);
      wait_drv(1'b1, n);
      chk("up cycles", n, UP);
      cyc(2);
      chk("ready", status.pwr_ready, 1'b1);
   endtask
   task t_therm;
      ana.temp_hot = 1'b1;
      #1 chk("hot drv", drv_en, 1'b0);
      cyc(2);
      chk("therm flag", status.therm_off, 1'b1);
      ana.temp_hot  = 1'b0;
      ana.temp_safe = 1'b1;
      cyc(30);
      ana.temp_safe = 1'b0;
      cyc(1);
      ana.temp_safe = 1'b1;
      cyc(TH - 3);
      chk("cool early", drv_en, 1'b0);
      wait_drv(1'b1, n);
      chk("cool back", n <= 5 && drv_en === 1'b1, 1'b1);
   endtask
   task t_short;
      ana.short_det = 1'b1;
      cyc(SD - 2);
      ana.short_det = 1'b0;
      cyc(3);
      chk("brief short", drv_en, 1'b1);
      ana.short_det = 1'b1;
      wait_drv(1'b0, n);
      chk("short det", n >= SD && n <= SD + 2, 1'b1);
      wait_drv(1'b1, n);
      chk("short off", n >= SO - 1 && n <= SO + 2, 1'b1);
      wait_drv(1'b0, n);
      chk("retry det", n >= SD && n <= SD + 2, 1'b1);
      ana.short_det = 1'b0;
      wait_drv(1'b1, n);
      chk("retry off", n >= SO - 1 && n <= SO + 2, 1'b1);
      cyc(SD + 5);
      chk("short gone", drv_en, 1'b1);
   endtask
   task t_uvlo;
      ana.uvlo = 1'b1;
      #1 chk("uv drv", drv_en, 1'b0);
      cyc(3);
      chk("uv bias", bias_en, 1'b1);
      chk("uv flag", status.uvlo_off, 1'b1);
      ana.uvlo = 1'b0;
      cyc(1);
      chk("uv back", drv_en, 1'b1);
   endtask
   // Power-on reset in mid-run while the drivers are on; enable stays high through it.
   task t_por;
      rst_b = 1'b0;
      #1 chk("por drv", drv_en, 1'b0);
      chk("por bias", bias_en, 1'b0);
      chk("por status", status, 4'h0);
      cyc(2);
      rst_b = 1'b1;
      wait_drv(1'b1, n);
      chk("por up", n, UP + 1);
   endtask
   task t_down;
      want_en <= 1'b0;
      wait_drv(1'b0, n);
      chk("down drv", n <= 3, 1'b1);
      chk("down bias", bias_en, 1'b0);
      want_en <= 1'b1;
      cyc(3);
      chk("down refused", bias_en, 1'b0);
      n = 0;
      while (bias_en !== 1'b1 && n < DN + 10) begin
         cyc(1);
         n++;
      end
      // Power-down began four falling edges before counting started; restart adds two edges.
      chk("down length", n, DN - 2);
      wait_drv(1'b1, n);
      chk("restart", n, UP);
      want_en <= 1'b0;
      cyc(DN + 6);
      chk("off status", status, 4'h0);
      chk("mute at toggle", mute_bad, 0);
   endtask
   task t_sweep;
      logic [FREQ_W-1:0] lo, hi, prev;
      int                bad;
      lo   = pwm_freq_hz;
      hi   = lo;
      prev = lo;
      bad  = 0;
      repeat (78000) begin
         cyc(1);
         if (pwm_freq_hz !== prev) begin
            if (pwm_freq_hz - prev !== 32'h0000_03E8 && prev - pwm_freq_hz !== 32'h0000_03E8) bad++;
            prev = pwm_freq_hz;
         end
         if (pwm_freq_hz < lo) lo = pwm_freq_hz;
         if (pwm_freq_hz > hi) hi = pwm_freq_hz;
      end
      chk("sweep hi", hi, 32'h0004_CE78);
      chk("sweep lo", lo, 32'h0004_5948);
      chk("sweep step", bad, 0);
   endtask
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // The sweep scenario needs about 78,000 cycles and the others well under a thousand.
   initial begin
      repeat (90_000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
   initial begin
      rst_b   = 1'b0;
      want_en = 1'b0;
      ana     = '0;
      cyc(10);
      t_reset();
      t_powerup();
      t_therm();
      t_short();
      t_uvlo();
      t_por();
      t_down();
      t_sweep();
      tally_and_finish();
   end
endmodule // apps_prot_seq_tb
